// >>> design/esxop_core.sv
// Purpose: Executes nibble swap, zero skips, table reads and exclusive-OR instructions
// Assumes: Data and program memories answer one cycle after a registered read enable
// Notes:   A taken skip adds one dummy cycle before DONE
`timescale 1ns/1ps
`default_nettype none
// Function
// - Swap data nibbles into working register only
// - Skip next instruction when data byte zero
// - Taken skip inserts one dummy cycle
// - Copy byte to working register, skip if zero
// - Skip when selected data bit clear
// - Current-page table read to memory and high
// - Last-page table read to memory and high
// - Increment low pointer, read full pointer address
// - Increment low pointer, read last page
// - Exclusive-OR into working register, zero flag
// - Exclusive-OR into data memory, zero flag
module esxop_core #(
   parameter int ADDR_W = 9
) (
   // Clock and reset
   input  wire logic              CLK,
   input  wire logic              SRST,
   // Instruction issue
   input  wire logic              OP_VALID,
   input  wire logic [3:0]        OP_CODE,
   input  wire logic [2:0]        OP_BIT,
   input  wire logic [ADDR_W-1:0] OP_ADDR,
   input  wire logic [7:0]        CUR_PAGE,
   output logic                   READY,
   output logic                   DONE,
   output logic                   SKIP,
   // Data memory
   output logic                   DM_RD_EN,
   output logic      [ADDR_W-1:0] DM_ADDR,
   input  wire logic [7:0]        DM_RD_DATA,
   output logic                   DM_WR_EN,
   output logic      [7:0]        DM_WR_DATA,
   // Program memory
   output logic                   PM_RD_EN,
   output logic      [15:0]       PM_ADDR,
   input  wire logic [15:0]       PM_DATA,
   // Working register and zero flag
   input  wire logic              WREG_LOAD,
   input  wire logic [7:0]        WREG_LOAD_VAL,
   output logic      [7:0]        WREG,
   output logic                   ZFLAG_WE,
   output logic                   ZFLAG_VAL,
   // Table registers
   input  wire logic              TABLE_PTR_LOW_LOAD,
   input  wire logic [7:0]        TABLE_PTR_LOW_VAL,
   input  wire logic              TABLE_PTR_HIGH_LOAD,
   input  wire logic [7:0]        TABLE_PTR_HIGH_VAL,
   input  wire logic              TABLE_HIGH_LOAD,
   input  wire logic [7:0]        TABLE_HIGH_VAL,
   output logic      [7:0]        TABLE_PTR_LOW,
   output logic      [7:0]        TABLE_PTR_HIGH,
   output logic      [7:0]        TABLE_HIGH
);

   esxop_pkg::esxop_state_t state_q;
   esxop_pkg::esxop_state_t state_d;
   esxop_pkg::esxop_op_t    op_q;
   esxop_pkg::esxop_op_t    op_in;

   logic              ready_q;
   logic              done_q;
   logic              skip_q;
   logic              dm_rd_q;
   logic [ADDR_W-1:0] dm_addr_q;
   logic              dm_wr_q;
   logic [7:0]        dm_wdata_q;
   logic              pm_rd_q;
   logic [15:0]       pm_addr_q;
   logic [7:0]        wreg_q;
   logic [7:0]        wreg_d;
   logic              zwe_q;
   logic              zval_q;
   logic [2:0]        bit_q;

   logic              accept;
   logic              in_exec;
   logic              in_table;
   logic              in_preinc;
   logic              in_final;
   logic              in_current;
   logic              is_table;
   logic              is_exor;
   logic [7:0]        low_next;
   logic [15:0]       pm_addr_d;
   logic [7:0]        swap_val;
   logic [7:0]        xor_val;
   logic              byte_zero;
   logic              bit_zero;
   logic              skip_hit;
   logic              wreg_from_op;
   logic              dm_wr_d;
   logic [7:0]        dm_wdata_d;
   logic              tbh_take;

   // Instruction decode of the issued code
   assign op_in      = esxop_pkg::esxop_op_t'(OP_CODE);
   assign accept     = ready_q && OP_VALID;
   assign in_current = (op_in == esxop_pkg::OP_TABLE_READ_CURRENT_PAGE);
   assign in_final   = (op_in == esxop_pkg::OP_TABLE_READ_FINAL_PAGE) ||
                       (op_in == esxop_pkg::OP_PREINC_TABLE_READ_FINAL_PAGE);
   assign in_preinc  = (op_in == esxop_pkg::OP_PREINC_TABLE_READ) ||
                       (op_in == esxop_pkg::OP_PREINC_TABLE_READ_FINAL_PAGE);
   assign in_table   = in_current || in_final || in_preinc;

   // Low pointer seen by the table fetch, already incremented for pre-increment reads
   assign low_next = in_preinc ? 8'(TABLE_PTR_LOW + esxop_pkg::PTR_STEP) :
                     TABLE_PTR_LOW;

   // Program word address selection per table read kind
   assign pm_addr_d = in_current ? {CUR_PAGE, low_next} :
                      in_final   ? {{esxop_pkg::PAGE_W{1'b1}}, low_next} :
                                   {TABLE_PTR_HIGH, low_next};

   // Decode of the instruction held for execution
   assign in_exec  = (state_q == esxop_pkg::ST_EXEC);
   assign is_table = (op_q == esxop_pkg::OP_TABLE_READ_CURRENT_PAGE) ||
                     (op_q == esxop_pkg::OP_TABLE_READ_FINAL_PAGE) ||
                     (op_q == esxop_pkg::OP_PREINC_TABLE_READ) ||
                     (op_q == esxop_pkg::OP_PREINC_TABLE_READ_FINAL_PAGE);
   assign is_exor  = (op_q == esxop_pkg::OP_EXOR_TO_WREG) ||
                     (op_q == esxop_pkg::OP_EXOR_TO_MEMORY);

   // Operand functions on the returned data byte
   assign swap_val  = {DM_RD_DATA[3:0], DM_RD_DATA[7:4]};
   assign xor_val   = wreg_q ^ DM_RD_DATA;
   assign byte_zero = (DM_RD_DATA == esxop_pkg::ZERO_BYTE);
   assign bit_zero  = ~DM_RD_DATA[bit_q];

   // Skip decision, no flag touched
   assign skip_hit = in_exec &&
                     ((((op_q == esxop_pkg::OP_SKIP_IF_NULL_BYTE) ||
                        (op_q == esxop_pkg::OP_COPY_AND_SKIP_IF_NULL)) && byte_zero) ||
                      ((op_q == esxop_pkg::OP_SKIP_IF_BIT_CLEAR) && bit_zero));

   // Working register source; execution wins over a core load
   assign wreg_from_op = in_exec &&
                         ((op_q == esxop_pkg::OP_NIBBLE_SWAP_TO_WREG) ||
                          (op_q == esxop_pkg::OP_COPY_AND_SKIP_IF_NULL) ||
                          (op_q == esxop_pkg::OP_EXOR_TO_WREG));
   assign wreg_d = !wreg_from_op ? (WREG_LOAD ? WREG_LOAD_VAL : wreg_q) :
                   (op_q == esxop_pkg::OP_NIBBLE_SWAP_TO_WREG) ? swap_val :
                   (op_q == esxop_pkg::OP_COPY_AND_SKIP_IF_NULL) ? DM_RD_DATA :
                   xor_val;

   // Data memory write back for table reads and memory exclusive-OR
   assign dm_wr_d    = in_exec && (is_table || (op_q == esxop_pkg::OP_EXOR_TO_MEMORY));
   assign dm_wdata_d = is_table ? PM_DATA[7:0] : xor_val;
   assign tbh_take   = in_exec && is_table;

   // Sequencer next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         esxop_pkg::ST_IDLE: begin
            if (accept) begin
               state_d = esxop_pkg::ST_READ;
            end
         end
         esxop_pkg::ST_READ: state_d = esxop_pkg::ST_EXEC;
         esxop_pkg::ST_EXEC: begin
            state_d = skip_hit ? esxop_pkg::ST_DUMMY : esxop_pkg::ST_IDLE;
         end
         default: state_d = esxop_pkg::ST_IDLE;
      endcase
   end

   // Sequencer and handshake flags
   always_ff @(posedge CLK) begin
      if (SRST) begin
         state_q <= esxop_pkg::ST_IDLE;
         ready_q <= 1'b1;
         done_q  <= 1'b0;
         skip_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         ready_q <= (state_d == esxop_pkg::ST_IDLE);
         done_q  <= (in_exec && !skip_hit) || (state_q == esxop_pkg::ST_DUMMY);
         skip_q  <= skip_hit;
      end
   end

   // Captured instruction and memory reads
   always_ff @(posedge CLK) begin
      if (SRST) begin
         op_q      <= esxop_pkg::OP_NIBBLE_SWAP_TO_WREG;
         bit_q     <= 3'h0;
         dm_rd_q   <= 1'b0;
         dm_addr_q <= '0;
         pm_rd_q   <= 1'b0;
         pm_addr_q <= esxop_pkg::PM_RST;
      end else begin
         dm_rd_q <= accept && !in_table;
         pm_rd_q <= accept && in_table;
         if (accept) begin
            op_q      <= op_in;
            bit_q     <= OP_BIT;
            dm_addr_q <= OP_ADDR;
            pm_addr_q <= pm_addr_d;
         end
      end
   end

   // Results: write back, working register and zero flag
   always_ff @(posedge CLK) begin
      if (SRST) begin
         wreg_q     <= esxop_pkg::WREG_RST;
         dm_wr_q    <= 1'b0;
         dm_wdata_q <= esxop_pkg::ZERO_BYTE;
         zwe_q      <= 1'b0;
         zval_q     <= 1'b0;
      end else begin
         wreg_q     <= wreg_d;
         dm_wr_q    <= dm_wr_d;
         dm_wdata_q <= dm_wdata_d;
         zwe_q      <= in_exec && is_exor;
         zval_q     <= (xor_val == esxop_pkg::ZERO_BYTE);
      end
   end

   // Table pointer and high-byte storage
   esxop_tblregs u_tblregs (
      .clk           (CLK),
      .srst          (SRST),
      .low_load      (TABLE_PTR_LOW_LOAD),
      .low_val       (TABLE_PTR_LOW_VAL),
      .high_load     (TABLE_PTR_HIGH_LOAD),
      .high_val      (TABLE_PTR_HIGH_VAL),
      .low_inc       (accept && in_preinc),
      .tbh_load      (tbh_take),
      .tbh_val       (PM_DATA[15:8]),
      .tbh_core_load (TABLE_HIGH_LOAD),
      .tbh_core_val  (TABLE_HIGH_VAL),
      .ptr_low       (TABLE_PTR_LOW),
      .ptr_high      (TABLE_PTR_HIGH),
      .tbh           (TABLE_HIGH)
   );

   // Port drive from flip-flops
   assign READY      = ready_q;
   assign DONE       = done_q;
   assign SKIP       = skip_q;
   assign DM_RD_EN   = dm_rd_q;
   assign DM_ADDR    = dm_addr_q;
   assign DM_WR_EN   = dm_wr_q;
   assign DM_WR_DATA = dm_wdata_q;
   assign PM_RD_EN   = pm_rd_q;
   assign PM_ADDR    = pm_addr_q;
   assign WREG       = wreg_q;
   assign ZFLAG_WE   = zwe_q;
   assign ZFLAG_VAL  = zval_q;

   // Helper copies of returned data and the working register for checks
   logic [7:0]  dm_seen_q;
   logic [15:0] pm_seen_q;
   logic [7:0]  wreg_seen_q;
   always_ff @(posedge CLK) begin
      dm_seen_q   <= DM_RD_DATA;
      pm_seen_q   <= PM_DATA;
      wreg_seen_q <= wreg_q;
   end

   // Issue of one instruction kind
   sequence s_issue(logic [3:0] code);
      OP_VALID && READY && (OP_CODE == code);
   endsequence
   // Issue followed by the data return cycle
   sequence s_exec(logic [3:0] code);
      s_issue(code) ##2 1'b1;
   endsequence

   a_swap_to_wreg: assert property (@(posedge CLK) disable iff (SRST)
      s_exec(4'(esxop_pkg::OP_NIBBLE_SWAP_TO_WREG)) |->
      ##1 (WREG == {dm_seen_q[3:0], dm_seen_q[7:4]}) && !DM_WR_EN && !ZFLAG_WE)
      else $error("nibble swap result wrong");
   a_null_byte_skip: assert property (@(posedge CLK) disable iff (SRST)
      s_exec(4'(esxop_pkg::OP_SKIP_IF_NULL_BYTE)) |->
      ##1 (SKIP == (dm_seen_q == 8'h00)) && (DONE == (dm_seen_q != 8'h00)) && !ZFLAG_WE)
      else $error("zero byte skip wrong");
   a_dummy_cycle: assert property (@(posedge CLK) disable iff (SRST)
      SKIP |-> !READY && !DONE ##1 DONE && READY && !SKIP)
      else $error("skip dummy cycle wrong");
   a_copy_and_skip: assert property (@(posedge CLK) disable iff (SRST)
      s_exec(4'(esxop_pkg::OP_COPY_AND_SKIP_IF_NULL)) |->
      ##1 (WREG == dm_seen_q) && (SKIP == (dm_seen_q == 8'h00)) && !ZFLAG_WE)
      else $error("copy and skip wrong");
   a_bit_clear_skip: assert property (@(posedge CLK) disable iff (SRST)
      s_exec(4'(esxop_pkg::OP_SKIP_IF_BIT_CLEAR)) |->
      ##1 (SKIP == !dm_seen_q[bit_q]) && !ZFLAG_WE && !DM_WR_EN)
      else $error("bit clear skip wrong");
   a_current_page: assert property (@(posedge CLK) disable iff (SRST)
      s_issue(4'(esxop_pkg::OP_TABLE_READ_CURRENT_PAGE)) |->
      ##1 PM_RD_EN && (PM_ADDR[15:8] == $past(CUR_PAGE)) &&
      (PM_ADDR[7:0] == $past(TABLE_PTR_LOW)))
      else $error("current page address wrong");
   a_final_page: assert property (@(posedge CLK) disable iff (SRST)
      s_issue(4'(esxop_pkg::OP_TABLE_READ_FINAL_PAGE)) |->
      ##1 PM_RD_EN && (PM_ADDR[15:8] == 8'hff) && (PM_ADDR[7:0] == $past(TABLE_PTR_LOW)))
      else $error("final page address wrong");
   a_preinc_address: assert property (@(posedge CLK) disable iff (SRST)
      s_issue(4'(esxop_pkg::OP_PREINC_TABLE_READ)) |->
      ##1 (TABLE_PTR_LOW == 8'($past(TABLE_PTR_LOW) + 8'h01)) &&
      (PM_ADDR == {$past(TABLE_PTR_HIGH), TABLE_PTR_LOW}) && PM_RD_EN)
      else $error("preincrement address wrong");
   a_preinc_final: assert property (@(posedge CLK) disable iff (SRST)
      s_issue(4'(esxop_pkg::OP_PREINC_TABLE_READ_FINAL_PAGE)) |->
      ##1 (PM_ADDR == {8'hff, 8'($past(TABLE_PTR_LOW) + 8'h01)}) && PM_RD_EN)
      else $error("preincrement final page wrong");
   a_table_store: assert property (@(posedge CLK) disable iff (SRST)
      $rose(pm_rd_q) ##1 1'b1 |->
      ##1 DM_WR_EN && (DM_WR_DATA == pm_seen_q[7:0]) && (TABLE_HIGH == pm_seen_q[15:8]))
      else $error("table store wrong");
   a_no_high_carry: assert property (@(posedge CLK) disable iff (SRST)
      (OP_VALID && READY && (TABLE_PTR_LOW == 8'hff) && !TABLE_PTR_HIGH_LOAD &&
       ((OP_CODE == 4'(esxop_pkg::OP_PREINC_TABLE_READ)) ||
        (OP_CODE == 4'(esxop_pkg::OP_PREINC_TABLE_READ_FINAL_PAGE)))) |->
      ##1 (TABLE_PTR_LOW == 8'h00) && $stable(TABLE_PTR_HIGH))
      else $error("pointer increment carried");
   a_exor_to_wreg: assert property (@(posedge CLK) disable iff (SRST)
      s_exec(4'(esxop_pkg::OP_EXOR_TO_WREG)) |->
      ##1 (WREG == (wreg_seen_q ^ dm_seen_q)) && ZFLAG_WE &&
      (ZFLAG_VAL == (WREG == 8'h00)) && !DM_WR_EN)
      else $error("exclusive-or to wreg wrong");
   a_exor_to_memory: assert property (@(posedge CLK) disable iff (SRST)
      s_exec(4'(esxop_pkg::OP_EXOR_TO_MEMORY)) |->
      ##1 DM_WR_EN && (DM_WR_DATA == (wreg_seen_q ^ dm_seen_q)) && ZFLAG_WE &&
      (ZFLAG_VAL == (DM_WR_DATA == 8'h00)))
      else $error("exclusive-or to memory wrong");

endmodule
`default_nettype wire

// >>> design/esxop_tblregs.sv
// Purpose: Table pointer low/high and table high-byte register storage
// Assumes: Single clock, synchronous active-high reset
// Notes:   Pre-increment has priority over a core load of the low pointer
`timescale 1ns/1ps
`default_nettype none
module esxop_tblregs (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       srst,
   // Core loads
   input  wire logic       low_load,
   input  wire logic [7:0] low_val,
   input  wire logic       high_load,
   input  wire logic [7:0] high_val,
   // Table read effects and core load of the table high byte
   input  wire logic       low_inc,
   input  wire logic       tbh_load,
   input  wire logic [7:0] tbh_val,
   input  wire logic       tbh_core_load,
   input  wire logic [7:0] tbh_core_val,
   // Register values
   output logic      [7:0] ptr_low,
   output logic      [7:0] ptr_high,
   output logic      [7:0] tbh
);

   logic [7:0] low_q;
   logic [7:0] low_d;
   logic [7:0] high_q;
   logic [7:0] high_d;
   logic [7:0] tbh_q;
   logic [7:0] tbh_d;

   // Next values; the increment wraps inside the low byte only
   assign low_d  = low_inc ? 8'(low_q + esxop_pkg::PTR_STEP) :
                   low_load ? low_val : low_q;
   assign high_d = high_load ? high_val : high_q;
   assign tbh_d  = tbh_load ? tbh_val : (tbh_core_load ? tbh_core_val : tbh_q);

   // Register update
   always_ff @(posedge clk) begin
      if (srst) begin
         low_q  <= esxop_pkg::TPL_RST;
         high_q <= esxop_pkg::TPH_RST;
         tbh_q  <= esxop_pkg::TBH_RST;
      end else begin
         low_q  <= low_d;
         high_q <= high_d;
         tbh_q  <= tbh_d;
      end
   end

   assign ptr_low  = low_q;
   assign ptr_high = high_q;
   assign tbh      = tbh_q;

endmodule
`default_nettype wire

// >>> inc/esxop_pkg.sv
// Purpose: Shared constants and types for the extended skip, table and exclusive-OR unit
// Assumes: 8-bit data memory, 16-bit program words, 256-word table pages
// Notes:   Opcode values follow the declaration order of esxop_op_t
package esxop_pkg;

   // Data path widths
   localparam int DATA_W    = 8;
   localparam int NIB_W     = 4;
   localparam int PM_WORD_W = 16;
   localparam int PM_AW     = 16;
   localparam int PAGE_W    = 8;
   localparam int BIT_SEL_W = 3;
   localparam int OP_W      = 4;

   // Reset values, zero byte and pointer step
   localparam logic [7:0]  TPL_RST   = 8'h00;
   localparam logic [7:0]  TPH_RST   = 8'h00;
   localparam logic [7:0]  TBH_RST   = 8'h00;
   localparam logic [7:0]  WREG_RST  = 8'h00;
   localparam logic [7:0]  ZERO_BYTE = 8'h00;
   localparam logic [7:0]  PTR_STEP  = 8'h01;
   localparam logic [15:0] PM_RST    = 16'h0000;

   // Instruction group handled by this unit
   typedef enum logic [3:0] {
      OP_NIBBLE_SWAP_TO_WREG,
      OP_SKIP_IF_NULL_BYTE,
      OP_COPY_AND_SKIP_IF_NULL,
      OP_SKIP_IF_BIT_CLEAR,
      OP_TABLE_READ_CURRENT_PAGE,
      OP_TABLE_READ_FINAL_PAGE,
      OP_PREINC_TABLE_READ,
      OP_PREINC_TABLE_READ_FINAL_PAGE,
      OP_EXOR_TO_WREG,
      OP_EXOR_TO_MEMORY
   } esxop_op_t;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_READ,
      ST_EXEC,
      ST_DUMMY
   } esxop_state_t;

endpackage

// >>> sim/tb.sv
// Purpose: Self-checking bench for the extended skip, table and exclusive-OR unit
// Assumes: Bench plays the core, data memory and program memory with one-cycle latency
// Notes:   Random instruction stream with directed corners and a mid-run reset
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam int AW = 9;
   logic          clk, srst, op_valid, ready, done, skip;
   logic [3:0]    op_code;
   logic [2:0]    op_bit;
   logic [AW-1:0] op_addr, dm_addr;
   logic [7:0]    cur_page, dm_rd_data, dm_wr_data, wreg, wreg_val;
   logic          dm_rd_en, dm_wr_en, pm_rd_en, zflag_we, zflag_val;
   logic [15:0]   pm_addr, pm_data;
   logic          wreg_load, tpl_load, tph_load, tbh_load;
   logic [7:0]    tpl_val, tph_val, tbh_val, tpl, tph, tbh;
   logic [7:0]    m_wreg, m_tpl, m_tph, m_tbh;
   logic [7:0]    d;
   logic [31:0]   r, r2;
   integer        seed;
   int            num_errors, comparisons, i;

   // Unit under test
   esxop_core #(.ADDR_W(AW)) dut (
      .CLK(clk), .SRST(srst), .OP_VALID(op_valid), .OP_CODE(op_code), .OP_BIT(op_bit),
      .OP_ADDR(op_addr), .CUR_PAGE(cur_page), .READY(ready), .DONE(done), .SKIP(skip),
      .DM_RD_EN(dm_rd_en), .DM_ADDR(dm_addr), .DM_RD_DATA(dm_rd_data),
      .DM_WR_EN(dm_wr_en), .DM_WR_DATA(dm_wr_data), .PM_RD_EN(pm_rd_en),
      .PM_ADDR(pm_addr), .PM_DATA(pm_data), .WREG_LOAD(wreg_load),
      .WREG_LOAD_VAL(wreg_val), .WREG(wreg), .ZFLAG_WE(zflag_we), .ZFLAG_VAL(zflag_val),
      .TABLE_PTR_LOW_LOAD(tpl_load), .TABLE_PTR_LOW_VAL(tpl_val),
      .TABLE_PTR_HIGH_LOAD(tph_load), .TABLE_PTR_HIGH_VAL(tph_val),
      .TABLE_HIGH_LOAD(tbh_load), .TABLE_HIGH_VAL(tbh_val), .TABLE_PTR_LOW(tpl),
      .TABLE_PTR_HIGH(tph), .TABLE_HIGH(tbh)
   );

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Final report and end of run
   task automatic give_verdict();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Compare seen against expected
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Expected effects of one instruction; updates the register model
   function automatic void predict(input logic [3:0] c, input logic [2:0] b,
         input logic [7:0] dv, input logic [15:0] p, input logic [7:0] pg,
         output logic sk, output logic [8:0] wr, output logic [1:0] zf,
         output logic [16:0] pa);
      logic [7:0] x;
      x = m_wreg ^ dv;
      sk = 1'b0;
      wr = 9'h000;
      zf = 2'h0;
      pa = 17'h00000;
      case (c)
         4'h0: m_wreg = {dv[3:0], dv[7:4]};
         4'h1: sk = (dv == 8'h00);
         4'h2: begin
            m_wreg = dv;
            sk = (dv == 8'h00);
         end
         4'h3: sk = !dv[b];
         4'h4, 4'h5, 4'h6, 4'h7: begin
            if (c[1])
               m_tpl = m_tpl + 8'h01;
            pa = {1'b1, (c[0] ? 8'hff : (c[1] ? m_tph : pg)), m_tpl};
            wr = {1'b1, p[7:0]};
            m_tbh = p[15:8];
         end
         4'h8: begin
            m_wreg = x;
            zf = {1'b1, x == 8'h00};
         end
         4'h9: begin
            wr = {1'b1, x};
            zf = {1'b1, x == 8'h00};
         end
         default: ;
      endcase
   endfunction

   // Core loads of working and table registers, selected by en
   task automatic load_regs(input logic [7:0] w, tl, th, hv, input logic [3:0] en);
      wreg_load = en[0];
      wreg_val = w;
      tpl_load = en[1];
      tpl_val = tl;
      tph_load = en[2];
      tph_val = th;
      tbh_load = en[3];
      tbh_val = hv;
      @(negedge clk);
      {wreg_load, tpl_load, tph_load, tbh_load} = 4'h0;
      if (en[0]) m_wreg = w;
      if (en[1]) m_tpl = tl;
      if (en[2]) m_tph = th;
      if (en[3]) m_tbh = hv;
   endtask

   // Offer one instruction, act as both memories, check every effect
   task automatic run_op(input logic [3:0] c, input logic [2:0] b,
         input logic [AW-1:0] a, input logic [7:0] dv, input logic [15:0] p,
         input logic [7:0] pg);
      logic        sk, s_sk;
      logic [8:0]  wr, s_wr;
      logic [1:0]  zf, s_zf;
      logic [16:0] pa, s_pa;
      logic [31:0] q;
      int          n, dc, rd;
      predict(c, b, dv, p, pg, sk, wr, zf, pa);
      s_sk = 1'b0;
      s_wr = 9'h000;
      s_zf = 2'h0;
      s_pa = 17'h00000;
      dc = 0;
      rd = 0;
      op_valid = 1'b1;
      op_code = c;
      op_bit = b;
      op_addr = a;
      cur_page = pg;
      dm_rd_data = dv;
      pm_data = p;
      for (n = 1; n <= 8 && dc == 0; n++) begin
         @(negedge clk);
         if (n == 1) begin
            q = $random(seed);
            op_code = q[3:0];
            op_addr = q[AW+3:4];
            cur_page = q[31:24];
            op_valid = q[31];
         end
         if (n == 2)
            op_valid = 1'b0;
         if (skip === 1'b1) s_sk = 1'b1;
         if (dm_rd_en === 1'b1) rd += n;
         if (dm_wr_en === 1'b1) s_wr = {1'b1, dm_wr_data};
         if (zflag_we === 1'b1) s_zf = {1'b1, zflag_val};
         if (pm_rd_en === 1'b1) s_pa = {1'b1, pm_addr};
         if (done === 1'b1) dc = n;
      end
      if (dc == 0) begin
         num_errors++;
         give_verdict();
      end
      dm_rd_data = ~dv;
      pm_data = ~p;
      check(17'(dc), sk ? 17'h00004 : 17'h00003);
      check(17'(s_sk), 17'(sk));
      check(17'(rd), (c >= 4'h4 && c <= 4'h7) ? 17'h00000 : 17'h00001);
      check(17'(s_wr), 17'(wr));
      check(17'(s_zf), 17'(zf));
      check(s_pa, pa);
      check(17'(wreg), 17'(m_wreg));
      check(17'({tph, tpl}), 17'({m_tph, m_tpl}));
      check(17'(tbh), 17'(m_tbh));
      if (c < 4'ha)
         check(17'(dm_addr), 17'(a));
   endtask

   // Hold reset, then check idle state
   task automatic do_reset(input int cycles);
      srst = 1'b1;
      repeat (cycles) @(negedge clk);
      srst = 1'b0;
      {m_wreg, m_tpl, m_tph, m_tbh} = 32'h00000000;
      check(17'({ready, done, skip, wreg}), 17'h00400);
      check(17'({tph, tpl}), 17'h00000);
      check(17'(tbh), 17'h00000);
   endtask

   // Main sequence
   initial begin
      seed = 32'h47ebb92e;
      num_errors = 0;
      comparisons = 0;
      {op_valid, op_code, op_bit, op_addr, cur_page} = '0;
      {dm_rd_data, pm_data} = '0;
      {wreg_load, wreg_val, tpl_load, tpl_val} = '0;
      {tph_load, tph_val, tbh_load, tbh_val} = '0;
      do_reset(10);
      // Pointer wrap on both pre-increment reads
      load_regs(8'h5a, 8'hff, 8'h37, 8'h11, 4'hf);
      run_op(4'h6, 3'h0, 9'h010, 8'h00, 16'hbeef, 8'h22);
      load_regs(8'h00, 8'hff, 8'h00, 8'h00, 4'h2);
      run_op(4'h7, 3'h0, 9'h1ff, 8'h00, 16'h1234, 8'h22);
      // Every bit position, clear and set
      for (i = 0; i < 8; i++) begin
         run_op(4'h3, 3'(i), 9'h044, ~(8'h01 << i), 16'h0000, 8'h00);
         run_op(4'h3, 3'(i), 9'h045, 8'h01 << i, 16'h0000, 8'h00);
      end
      // Every code with a zero byte, then with an all-ones byte
      for (i = 0; i < 32; i++)
         run_op(4'(i), 3'h7, 9'h100, i < 16 ? 8'h00 : 8'hff, 16'ha55a, 8'h3c);
      // Exclusive-OR giving zero
      load_regs(8'h3c, 8'h00, 8'h00, 8'h00, 4'h1);
      run_op(4'h8, 3'h0, 9'h002, 8'h3c, 16'h0000, 8'h00);
      run_op(4'h9, 3'h0, 9'h003, 8'h00, 16'h0000, 8'h00);
      // Random stream, back to back
      for (i = 0; i < 400; i++) begin
         r = $random(seed);
         r2 = $random(seed);
         if (r[7:6] == 2'h0)
            load_regs(r2[7:0], r2[15:8], r2[23:16], r2[31:24], r[11:8]);
         d = r[15:8];
         if (r[5:4] == 2'h0)
            d = 8'h00;
         run_op(r[3:0], r[18:16], r2[AW-1:0], d, r2[31:16], r[31:24]);
         if (i == 200) begin
            load_regs(r2[7:0], r2[15:8], r2[23:16], r2[31:24], 4'hf);
            do_reset(2);
         end
      end
      give_verdict();
   end
endmodule
`default_nettype wire
